// ===== bench/irq_mgr_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "phy_irq_defines.vh"
// ****************************************
// bus answer and output checks
// ****************************************
module irq_mgr_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        awready,
  input wire logic        awvalid,
  input wire logic        wready,
  input wire logic        wvalid,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        irq,
  input wire logic        irq_out_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // both write halves taken at one edge
  sequence wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence rd_take;
    arvalid && arready;
  endsequence
  pin_inverse_a: assert property (irq_out_n == !irq) else $error("pin not inverse");
  wr_answer_a: assert property (wr_take |=> !awready && !wready ##1 bvalid)
    else $error("write answer late");
  rd_answer_a: assert property (rd_take |=> rvalid && !arready) else $error("read answer late");
  rd_unused_a: assert property ((rd_take and (araddr > 32'hc))
    |=> rresp == `RESP_SLVERR && rdata == 0) else $error("unmapped read answered");
  rd_width_a: assert property ((rd_take and (araddr <= 32'hc)) |=> rdata[31:8] == 0)
    else $error("upper bits set");
  b_hold_a: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  b_end_a: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
  r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data moved");
  ar_block_a: assert property (rvalid |-> !arready) else $error("second read taken");
endmodule // irq_mgr_sva
bind phy_interrupt_manager irq_mgr_sva chk_u (.clk(clk), .nrst(nrst), .awready(awready),
  .awvalid(awvalid), .wready(wready), .wvalid(wvalid), .bvalid(bvalid), .bready(bready),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .irq(irq), .irq_out_n(irq_out_n));
`default_nettype wire

// ===== bench/phy_interrupt_manager_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "phy_irq_defines.vh"
// ****************************************
// bench top
// ****************************************
module phy_interrupt_manager_tb;
  logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr;
  logic [7:1]  lvl;
  logic [2:0]  pul;
  wire  [7:1]  src;
  wire         awready, wready, bvalid, arready, rvalid, irq, irq_out_n;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  integer      fails, samples_checked, cycles;
  // short counts keep the reassert test quick
  src_model src_u (.clk(clk), .lvl(lvl), .src(src));
  phy_interrupt_manager #(.PULSE_CYCLES(32'd20), .DELAY_CYCLES(32'd30)) dut_u (
    .clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .energy_present(src[7]), .an_complete(src[6]), .remote_fault(src[5]),
    .link_status(src[4]), .partner_ack(src[3]), .par_det_fault(src[2]),
    .page_received(src[1]), .basic_status_read(pul[0]), .expansion_read(pul[1]),
    .an_restart(pul[2]), .irq(irq), .irq_out_n(irq_out_n));
  always #5 clk = ~clk;
  task results;
    begin
      $display("checked %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails = fails + 1;
      results;
    end
  end
  task chk(input string n, input [31:0] e, input [31:0] s);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", n, e, s);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task ci(input e);
    begin
      cyc(2);
      chk("irq", {31'h0, e}, {31'h0, irq});
      chk("irq_out_n", {31'h0, ~e}, {31'h0, irq_out_n});
    end
  endtask
  // ready is raised late on purpose so the slave must hold its answer
  task wr(input [31:0] a, input [31:0] d);
    reg ta, tw;
    begin
      ta = 0;
      tw = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (awready && !ta) begin ta = 1; awvalid <= 1'b0; end
        if (wready && !tw) begin tw = 1; wvalid <= 1'b0; end
      end while (!(ta && tw));
      do @(posedge clk); while (!bvalid);
      bready <= 1'b1;
      @(posedge clk);
      chk("bresp", {30'h0, `RESP_OKAY}, {30'h0, bresp});
      bready <= 1'b0;
    end
  endtask
  task rd(input [31:0] a, input [31:0] e, input [1:0] r);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b1;
      @(posedge clk);
      chk("rdata", e, rdata);
      chk("rresp", {30'h0, r}, {30'h0, rresp});
      rready <= 1'b0;
    end
  endtask
  // one-cycle management pulse: 0 status read, 1 expansion read, 2 restart
  task pulse(input [2:0] p);
    begin
      pul <= p;
      @(posedge clk);
      pul <= 3'h0;
      cyc(3);
    end
  endtask
  // main sequence; energy and link start high
  initial begin
    clk = 0;
    nrst = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, wdata, araddr} = 96'h0;
    lvl = 7'h48;
    pul = 3'h0;
    {fails, samples_checked, cycles} = 96'h0;
    cyc(12);
    nrst <= 1'b1;
    cyc(2);
    rd(`ADDR_SOURCE, 32'h90, `RESP_OKAY);
    rd(`ADDR_MASK, 32'h0, `RESP_OKAY);
    rd(`ADDR_CTRL, 32'h0, `RESP_OKAY);
    rd(32'h10, 32'h0, `RESP_SLVERR);
    wr(`ADDR_MASK, 32'h80);
    ci(1);
    rd(`ADDR_FLAGS, 32'h80, `RESP_OKAY);
    ci(0);
    lvl[7] <= 1'b0;
    cyc(8);
    ci(0);
    cyc(26);
    ci(1);
    cyc(28);
    ci(0);
    wr(`ADDR_MASK, 32'h0);
    lvl[5] <= 1'b1;
    cyc(8);
    ci(0);
    rd(`ADDR_FLAGS, 32'h20, `RESP_OKAY);
    lvl[5] <= 1'b0;
    wr(`ADDR_MASK, 32'hfe);
    lvl[6] <= 1'b1;
    cyc(8);
    ci(1);
    rd(`ADDR_FLAGS, 32'h40, `RESP_OKAY);
    ci(0);
    lvl[6] <= 1'b0;
    lvl[3] <= 1'b1;
    cyc(8);
    ci(1);
    lvl[3] <= 1'b0;
    cyc(8);
    ci(0);
    lvl[4] <= 1'b0;
    cyc(8);
    ci(1);
    pulse(3'h1);
    ci(0);
    lvl[4] <= 1'b1;
    lvl[1] <= 1'b1;
    cyc(8);
    ci(1);
    pulse(3'h4);
    ci(0);
    lvl[2] <= 1'b1;
    cyc(8);
    ci(1);
    pulse(3'h2);
    ci(0);
    lvl[2:1] <= 2'h0;
    wr(`ADDR_CTRL, 32'h1);
    rd(`ADDR_CTRL, 32'h1, `RESP_OKAY);
    lvl[3] <= 1'b1;
    cyc(8);
    ci(1);
    wr(`ADDR_FLAGS, 32'h08);
    ci(1);
    rd(`ADDR_FLAGS, 32'h08, `RESP_OKAY);
    lvl[3] <= 1'b0;
    cyc(8);
    ci(1);
    wr(`ADDR_FLAGS, 32'h08);
    ci(0);
    lvl[4] <= 1'b0;
    cyc(8);
    wr(`ADDR_FLAGS, 32'h10);
    ci(1);
    wr(`ADDR_MASK, 32'hee);
    ci(0);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    cyc(2);
    rd(`ADDR_CTRL, 32'h0, `RESP_OKAY);
    rd(`ADDR_MASK, 32'h0, `RESP_OKAY);
    ci(0);
    results;
  end
endmodule // phy_interrupt_manager_tb
`default_nettype wire

// ===== bench/src_model.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// transceiver status levels
// ****************************************
module src_model (
  input  wire logic       clk,
  input  wire logic [7:1] lvl,
  output var  logic [7:1] src
);
  // levels move only on edges, as the core's status logic does
  always_ff @(posedge clk) src <= lvl;
endmodule // src_model
`default_nettype wire

// ===== pkg/phy_irq_defines.vh
`ifndef PHY_IRQ_DEFINES_VH
`define PHY_IRQ_DEFINES_VH

// ****************************************
// register byte addresses
// ****************************************
`define ADDR_FLAGS    32'h0000_0000
`define ADDR_MASK     32'h0000_0004
`define ADDR_CTRL     32'h0000_0008
`define ADDR_SOURCE   32'h0000_000c

// ****************************************
// bus answers
// ****************************************
`define RESP_OKAY     2'b00
`define RESP_SLVERR   2'b10

// ****************************************
// field layout
// ****************************************
`define CTRL_ALT_BIT  0
`define SRC_BITS      8'hfe
`define ENERGY_BIT    7
`define LINK_BIT      4
// sources whose return to idle releases the flag in primary mode
`define LEVEL_CLR     8'hee
// flags also released by a basic status read
`define BSR_CLR       8'h30
// flags also released by expansion read, renegotiation, link loss
`define EXP_CLR       8'h06

// ****************************************
// reset values
// ****************************************
`define FLAG_RST      8'h80
`define SYNC_RST      8'h80
`define MASK_RST      8'h00
`define CTRL_RST      1'b0

// ****************************************
// timing
// ****************************************
`define CLK_KHZ       100000
`define PULSE_TIME_MS 256
`define DELAY_TIME_MS 1000

`endif

// ===== src/phy_interrupt_manager.v
// What this block does
// - drive active-low irq_out_n whenever an enabled source has an event
// - control bit selects mode: zero primary, one alternate, host writes it
// - after reset always primary mode; host reprograms alternate mode itself
// - both modes assert only for masked-in sources; only release differs
// - flags 7..1 map seven sources; link down falls, others rise
// - primary: release on source returning inactive (not link down) or flag register read
// - primary: basic status read releases remote fault and link down
// - primary: fault and page flags also released by expansion read, restart, loss
// - alternate: clearing a mask bit drops the output for that source
// - alternate: writing one tests source, clears flag only if released
// - alternate: release condition is source inactive; link down needs link up
// - energy released while present, then lost for one second, reasserts for 256 ms
// - energy status and its flag start at one after reset
// - mask one enables a source, zero masks it; masks reset to zero
`include "phy_irq_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module phy_interrupt_manager #(
  parameter [31:0] PULSE_CYCLES = `PULSE_TIME_MS * `CLK_KHZ,
  parameter [31:0] DELAY_CYCLES = `DELAY_TIME_MS * `CLK_KHZ
) (
  input  wire        clk,
  input  wire        nrst,
  // axi4-lite slave
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // source levels from the transceiver core
  input  wire        energy_present,
  input  wire        an_complete,
  input  wire        remote_fault,
  input  wire        link_status,
  input  wire        partner_ack,
  input  wire        par_det_fault,
  input  wire        page_received,
  // same-clock event pulses from the management logic
  input  wire        basic_status_read,
  input  wire        expansion_read,
  input  wire        an_restart,
  // interrupt outputs
  output reg         irq,
  output reg         irq_out_n
);

  // energy reassert sequencer: idle, waiting out the delay, pulsing the pin
  localparam [1:0] E_IDLE  = 2'h0;
  localparam [1:0] E_WAIT  = 2'h1;
  localparam [1:0] E_PULSE = 2'h2;

  // bit-indexable copies of the source layout; a shifted macro is eight bits
  // wide and would be cut silently where it meets a one-bit flop
  localparam [7:0] SYNC_INIT = `SYNC_RST;
  localparam [7:0] SRC_MASK  = `SRC_BITS;

  // ****************************************
  // source synchronisers and edge detect
  // ****************************************
  // bit 0 has no source and is tied low so flag bits line up with mask bits
  wire [7:0] src_raw = {energy_present, an_complete, remote_fault, link_status,
                        partner_ack, par_det_fault, page_received, 1'b0};
  reg  [7:0] sync_a;
  reg  [7:0] sync_b;
  reg  [7:0] src_prev;
  wire [7:0] act;
  wire [7:0] act_prev;
  wire [7:0] rise;

  // two synchroniser flops and one edge flop per source; energy starts high so power-up shows it present
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sync_a[gi]   <= SYNC_INIT[gi];
          sync_b[gi]   <= SYNC_INIT[gi];
          src_prev[gi] <= SYNC_INIT[gi];
        end else begin
          sync_a[gi]   <= src_raw[gi];
          sync_b[gi]   <= sync_a[gi];
          src_prev[gi] <= sync_b[gi];
        end
      end
      // link down is active when link status is low
      if (gi == `LINK_BIT) begin : g_inv
        assign act[gi]      = ~sync_b[gi];
        assign act_prev[gi] = ~src_prev[gi];
      end else begin : g_pass
        assign act[gi]      = sync_b[gi] & SRC_MASK[gi];
        assign act_prev[gi] = src_prev[gi] & SRC_MASK[gi];
      end
      assign rise[gi] = act[gi] & ~act_prev[gi];
    end
  endgenerate

  // link loss is the rising edge of the inverted link term
  wire link_fall = act[`LINK_BIT] & ~act_prev[`LINK_BIT];

  // ****************************************
  // software registers
  // ****************************************
  // flag, mask and mode state plus the energy reassert timer
  reg  [7:0] flags;
  reg  [7:0] mask;
  reg        alt_mode;
  reg  [7:0] next_flags;
  reg        armed;
  reg  [1:0] e_state;
  reg [31:0] e_count;

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  reg [31:0] aw_addr;
  reg        aw_full;
  reg [31:0] w_data;
  reg        w_strb0;
  reg        w_full;

  // a write executes once both halves are held and the last answer is
  // gone, which keeps exactly one write in flight
  wire       aw_take = awvalid & awready;
  wire       w_take  = wvalid & wready;
  wire       wr_go   = aw_full & w_full & ~bvalid;
  wire       next_aw_full = wr_go ? 1'b0 : (aw_full | aw_take);
  wire       next_w_full  = wr_go ? 1'b0 : (w_full | w_take);
  // register bits all sit in byte lane 0; the other strobes carry nothing
  wire       wr_lane = wr_go & w_strb0;
  wire       wr_flags = wr_lane & (aw_addr == `ADDR_FLAGS);
  wire       wr_mask  = wr_lane & (aw_addr == `ADDR_MASK);
  wire       wr_ctrl  = wr_lane & (aw_addr == `ADDR_CTRL);
  // anything outside the four words answers with an error and changes nothing
  wire       wr_known = (aw_addr == `ADDR_FLAGS) | (aw_addr == `ADDR_MASK) |
                        (aw_addr == `ADDR_CTRL) | (aw_addr == `ADDR_SOURCE);

  // address and data are held apart and may arrive in either order
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_addr <= 32'h0000_0000;
      aw_full <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb0 <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_data  <= wdata;
        w_strb0 <= wstrb[0];
      end
      // ready drops as soon as a half is held, so a second half waits on the bus
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= ~next_aw_full;
      wready  <= ~next_w_full;
      // the answer stands until bready; the next write waits on it via wr_go
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp  <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  // a flag read acts at the address handshake, the edge that captures rdata
  wire ar_take = arvalid & arready;
  wire rd_flags = ar_take & (araddr == `ADDR_FLAGS);

  // one read in flight; in primary mode the flag register read also releases flags
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RESP_OKAY;
      case (araddr)
        `ADDR_FLAGS:  rdata <= {24'h00_0000, flags};
        `ADDR_MASK:   rdata <= {24'h00_0000, mask};
        `ADDR_CTRL:   rdata <= {31'h0000_0000, alt_mode};
        `ADDR_SOURCE: rdata <= {24'h00_0000, sync_b & `SRC_BITS};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= `RESP_SLVERR;
        end
      endcase
    // arready returns only as the data is taken, so one read stays in flight
    end else if (rvalid & rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  // ****************************************
  // mode and mask registers
  // ****************************************
  // the mode bit never survives reset, so software must set it again
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alt_mode <= `CTRL_RST;
      mask     <= `MASK_RST;
    end else begin
      if (wr_ctrl) begin
        alt_mode <= w_data[`CTRL_ALT_BIT];
      end
      if (wr_mask) begin
        mask <= w_data[7:0] & `SRC_BITS;
      end
    end
  end

  // ****************************************
  // source flags
  // ****************************************
  // release terms per mode; a new edge in the same cycle wins over any release
  wire [7:0] prim_clr = (~act & `LEVEL_CLR) |
                        {8{rd_flags}} |
                        ({8{basic_status_read}} & `BSR_CLR) |
                        ({8{expansion_read | an_restart | link_fall}} & `EXP_CLR);
  wire [7:0] alt_clr  = {8{wr_flags}} & w_data[7:0] & ~act;
  wire [7:0] clr      = alt_mode ? alt_clr : prim_clr;

  // set terms win over release, and bit 0 never holds anything
  always @* begin
    next_flags = (rise | (flags & ~clr)) & `SRC_BITS;
  end

  // energy flag comes up set, matching the energy status at power-up
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flags <= `FLAG_RST;
    end else begin
      flags <= next_flags;
    end
  end

  // ****************************************
  // delayed energy reassertion
  // ****************************************
  // release of the energy flag and loss of energy, both from synchronised levels
  wire energy_cleared = flags[`ENERGY_BIT] & ~next_flags[`ENERGY_BIT];
  wire energy_fall    = ~act[`ENERGY_BIT] & act_prev[`ENERGY_BIT];
  // terminal count; each reload value is exactly the number of cycles spent
  wire e_last         = (e_count <= 32'h0000_0001);

  // arm when the energy flag is released while energy is still present;
  // a masked energy source never reasserts, hence the service hint
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed   <= 1'b0;
      e_state <= E_IDLE;
      e_count <= 32'h0000_0000;
    end else begin
      if (!mask[`ENERGY_BIT]) begin
        armed <= 1'b0;
      end else if (energy_cleared & act[`ENERGY_BIT]) begin
        armed <= 1'b1;
      end
      // delay and pulse share one down counter, so only one phase runs at a time
      case (e_state)
        E_IDLE: begin
          if (armed & energy_fall) begin
            e_state <= E_WAIT;
            e_count <= DELAY_CYCLES;
          end
        end
        E_WAIT: begin
          // energy back or mask cleared drops the pending reassert
          if (act[`ENERGY_BIT] | ~mask[`ENERGY_BIT]) begin
            e_state <= E_IDLE;
          end else if (e_last) begin
            e_state <= E_PULSE;
            e_count <= PULSE_CYCLES;
          end else begin
            e_count <= e_count - 32'h0000_0001;
          end
        end
        E_PULSE: begin
          // one pulse per arming; a fresh release is needed to arm again
          if (e_last || !mask[`ENERGY_BIT]) begin
            e_state <= E_IDLE;
            armed   <= 1'b0;
          end else begin
            e_count <= e_count - 32'h0000_0001;
          end
        end
        default: begin
          e_state <= E_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // interrupt output
  // ****************************************
  // the reassert pulse drives the pin without setting a flag; flag reads never show it
  wire pulse_on = (e_state == E_PULSE) & mask[`ENERGY_BIT];
  wire pend     = |(next_flags & mask) | pulse_on;

  // registered for a clean glitch-free pin; one clock of lag on each change
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq       <= 1'b0;
      irq_out_n <= 1'b1;
    end else begin
      irq       <= pend;
      irq_out_n <= ~pend;
    end
  end

endmodule // phy_interrupt_manager

`default_nettype wire
